// *** logic/blsr_startup_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module blsr_startup_ctrl import blsr_pkg::*; #(
    parameter int STARTUP_MS = BLSR_STARTUP_MS,
    parameter int LOSS_MS = BLSR_LOSS_MS,
    parameter int SIG_WAIT_MS = BLSR_SIG_WAIT_MS,
    parameter int DWELL_MS = BLSR_DWELL_MS,
    parameter int TONE_MS = BLSR_TONE_MS,
    parameter int SYMS_PER_MS = BLSR_SYMS_PER_MS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // receiver status
    input wire logic sym_tick_in,
    input wire logic sig_present_in,
    input wire logic network_side_wake_tone_in,
    input wire logic frame_lock_in,
    input wire logic multiframe_lock_in,
    // activation
    input wire logic cust_act_req_in,
    input wire logic near_activation_progress_bit_in,
    input wire logic far_activation_progress_bit_in,
    // transmitter control
    output logic [1:0] tx_mode_out,
    output logic tone_sym_pos_out,
    output logic inverted_sync_word_en_out,
    output logic bearer_force_one_out,
    output logic bearer_force_zero_out
);
    localparam logic [BLSR_TMR_W-1:0] T_START = BLSR_TMR_W'(STARTUP_MS);
    localparam logic [BLSR_TMR_W-1:0] T_LOSS = BLSR_TMR_W'(LOSS_MS);
    localparam logic [BLSR_TMR_W-1:0] T_SWAIT = BLSR_TMR_W'(SIG_WAIT_MS);
    localparam logic [BLSR_TMR_W-1:0] T_DWELL = BLSR_TMR_W'(DWELL_MS);
    localparam logic [BLSR_TMR_W-1:0] T_TONE = BLSR_TMR_W'(TONE_MS);
    localparam logic [6:0] SYM_LAST = 7'(SYMS_PER_MS - 1);
    localparam logic [BLSR_TMR_W-1:0] T_MAX = '1;

    typedef struct packed {
        blsr_state_t state;
        logic [6:0] symc;
        logic [BLSR_TMR_W-1:0] tmr;
        logic [BLSR_TMR_W-1:0] stmr;
        logic [BLSR_TMR_W-1:0] ltmr;
        logic [2:0] ph;
        logic pend;
        logic pwr;
        logic auto_en;
        logic loop_en;
        logic ack;
        logic [31:0] rdat;
    } blsr_regs_t;

    blsr_regs_t s_reg;
    blsr_regs_t s_next;
    logic ms_tick;
    logic bus_req;
    logic wr_ctrl;
    logic in_startup;

    // one millisecond base from the symbol clock
    assign ms_tick = sym_tick_in && (s_reg.symc == SYM_LAST);
    assign bus_req = wb_cyc_in && wb_stb_in && !s_reg.ack;
    assign wr_ctrl = bus_req && wb_we_in && wb_sel_in[0] && (wb_adr_in[7:2] == BLSR_CTRL_OFS[7:2]);
    assign in_startup = (s_reg.state == BLSR_WAKE_TONE) || (s_reg.state == BLSR_SIG_WAIT)
        || (s_reg.state == BLSR_ACQUIRE) || (s_reg.state == BLSR_PAT_TWO);

    always_comb begin
        s_next = s_reg;
        if (sym_tick_in) begin
            s_next.symc = (s_reg.symc == SYM_LAST) ? 7'h00 : s_reg.symc + 7'h01;
        end
        // request capture: a new request in the cycle it is consumed still survives
        if (cust_act_req_in || (wr_ctrl && wb_dat_in[BLSR_CTRL_REQ_BIT])) begin
            s_next.pend = 1'b1;
        end
        if (wr_ctrl) begin
            s_next.auto_en = wb_dat_in[BLSR_CTRL_AUTO_BIT];
            s_next.loop_en = wb_dat_in[BLSR_CTRL_LOOP_BIT];
        end
        unique case (s_reg.state)
            BLSR_FULL_RESET: begin
                if (network_side_wake_tone_in) begin
                    s_next.state = BLSR_WAKE_TONE;
                end else if (s_reg.pend || (s_reg.pwr && s_reg.auto_en)) begin
                    s_next.state = BLSR_WAKE_TONE;
                end
                if (s_next.state == BLSR_WAKE_TONE) begin
                    s_next.pend = cust_act_req_in || (wr_ctrl && wb_dat_in[BLSR_CTRL_REQ_BIT]);
                    s_next.pwr = 1'b0;
                end
            end
            BLSR_WAKE_TONE: begin
                if (s_reg.stmr >= T_START) begin
                    s_next.state = BLSR_CEASE;
                end else if (s_reg.tmr >= T_TONE) begin
                    s_next.state = BLSR_SIG_WAIT;
                end
            end
            BLSR_SIG_WAIT: begin
                // line termination stays quiet until our tone has stopped
                if (sig_present_in) begin
                    s_next.state = BLSR_ACQUIRE;
                end else if (s_reg.tmr >= T_SWAIT) begin
                    s_next.state = BLSR_FULL_RESET;
                end
            end
            BLSR_ACQUIRE: begin
                if (s_reg.stmr >= T_START) begin
                    s_next.state = BLSR_CEASE;
                end else if (frame_lock_in) begin
                    s_next.state = BLSR_PAT_TWO;
                end
            end
            BLSR_PAT_TWO: begin
                if (s_reg.stmr >= T_START) begin
                    s_next.state = BLSR_CEASE;
                end else if (multiframe_lock_in) begin
                    s_next.state = BLSR_OPER;
                end
            end
            BLSR_OPER: begin
                // stays here until a loss outlasts the supervision timer
                if (s_reg.ltmr >= T_LOSS) begin
                    if (!sig_present_in) begin
                        s_next.state = BLSR_RX_RESET;
                    end else begin
                        s_next.state = BLSR_CEASE;
                    end
                end
            end
            BLSR_CEASE: begin
                if (!sig_present_in) begin
                    s_next.state = BLSR_RX_RESET;
                end
            end
            BLSR_RX_RESET: begin
                if (network_side_wake_tone_in) begin
                    s_next.state = BLSR_WAKE_TONE;
                end else if (s_reg.tmr >= T_DWELL) begin
                    s_next.state = BLSR_FULL_RESET;
                end
            end
        endcase
        if (s_next.state != s_reg.state) begin
            s_next.tmr = '0;
        end else if (ms_tick && s_reg.tmr != T_MAX) begin
            s_next.tmr = s_reg.tmr + 1'b1;
        end
        // start-up timer spans the whole attempt from tone to operation
        if (!in_startup) begin
            s_next.stmr = '0;
        end else if (ms_tick && s_reg.stmr != T_MAX) begin
            s_next.stmr = s_reg.stmr + 1'b1;
        end
        // loss timer only runs once multiframe lock was reached
        if (s_reg.state != BLSR_OPER || (sig_present_in && frame_lock_in)) begin
            s_next.ltmr = '0;
        end else if (ms_tick && s_reg.ltmr != T_MAX) begin
            s_next.ltmr = s_reg.ltmr + 1'b1;
        end
        // tone phase: four symbols high, four low, 8 symbols per 10 kHz cycle
        if (s_reg.state != BLSR_WAKE_TONE) begin
            s_next.ph = 3'h0;
        end else if (sym_tick_in) begin
            s_next.ph = s_reg.ph + 3'h1;
        end
        s_next.ack = bus_req;
        if (bus_req) begin
            unique case (wb_adr_in[7:2])
                BLSR_CTRL_OFS[7:2]: begin
                    s_next.rdat = {29'h0, s_reg.loop_en, s_reg.auto_en, s_reg.pend};
                end
                BLSR_STATUS_OFS[7:2]: begin
                    s_next.rdat = {24'h0, s_reg.pwr, s_reg.pend, tx_mode_out, 1'b0, s_reg.state};
                end
                default: begin
                    s_next.rdat = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg.state <= BLSR_FULL_RESET;
            s_reg.symc <= 7'h00;
            s_reg.tmr <= '0;
            s_reg.stmr <= '0;
            s_reg.ltmr <= '0;
            s_reg.ph <= 3'h0;
            s_reg.pend <= 1'b0;
            s_reg.pwr <= 1'b1;
            s_reg.auto_en <= BLSR_AUTO_RST;
            s_reg.loop_en <= BLSR_LOOP_RST;
            s_reg.ack <= 1'b0;
            s_reg.rdat <= 32'h0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        unique case (s_reg.state)
            BLSR_WAKE_TONE: tx_mode_out = BLSR_TX_TONE;
            BLSR_PAT_TWO: tx_mode_out = BLSR_TX_PAT_TWO;
            BLSR_OPER: tx_mode_out = BLSR_TX_OPER;
            default: tx_mode_out = BLSR_TX_SILENT;
        endcase
    end

    assign wb_ack_out = s_reg.ack;
    assign wb_dat_out = s_reg.rdat;
    assign tone_sym_pos_out = !s_reg.ph[2];
    // inverted word marks the multiframe, present only in operation
    assign inverted_sync_word_en_out = (s_reg.state == BLSR_OPER);
    assign bearer_force_one_out = (s_reg.state == BLSR_PAT_TWO) || ((s_reg.state == BLSR_OPER) && !s_reg.loop_en
        && !(near_activation_progress_bit_in && far_activation_progress_bit_in));
    assign bearer_force_zero_out = 1'b0;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_tone_answer;
        (s_reg.state == BLSR_FULL_RESET) && network_side_wake_tone_in |=> tx_mode_out == BLSR_TX_TONE;
    endproperty
    a_tone_answer: assert property (p_tone_answer) else $error("network tone not answered");

    property p_dwell;
        (s_reg.state == BLSR_RX_RESET) && (s_reg.tmr < T_DWELL) && !network_side_wake_tone_in
            |=> s_reg.state == BLSR_RX_RESET;
    endproperty
    a_dwell: assert property (p_dwell) else $error("receive-reset left too early");

    property p_full_after_dwell;
        (s_reg.state == BLSR_RX_RESET) && (s_reg.tmr >= T_DWELL) && !network_side_wake_tone_in
            |=> s_reg.state == BLSR_FULL_RESET;
    endproperty
    a_full_after_dwell: assert property (p_full_after_dwell) else $error("no full reset after dwell");

    property p_los_direct;
        (s_reg.state == BLSR_OPER) && !sig_present_in && (s_reg.ltmr >= T_LOSS) |=> s_reg.state == BLSR_RX_RESET;
    endproperty
    a_los_direct: assert property (p_los_direct) else $error("loss of signal not to receive-reset");

    property p_loss_hold;
        (s_reg.state == BLSR_OPER) && (s_reg.ltmr < T_LOSS) |=> s_reg.state == BLSR_OPER;
    endproperty
    a_loss_hold: assert property (p_loss_hold) else $error("reset before loss timer expiry");

    property p_cease;
        (s_reg.state == BLSR_CEASE) |-> tx_mode_out == BLSR_TX_SILENT ##1
            (s_reg.state == (($past(sig_present_in)) ? BLSR_CEASE : BLSR_RX_RESET));
    endproperty
    a_cease: assert property (p_cease) else $error("cease sequence wrong");

    property p_armed;
        (s_reg.state != BLSR_OPER) |=> s_reg.ltmr == '0;
    endproperty
    a_armed: assert property (p_armed) else $error("loss timer ran before multiframe lock");

    property p_startup_to;
        in_startup && (s_reg.stmr >= T_START) && (s_reg.state != BLSR_SIG_WAIT) |=> s_reg.state == BLSR_CEASE;
    endproperty
    a_startup_to: assert property (p_startup_to) else $error("start-up timeout missed");

    property p_sig_wait;
        (s_reg.state == BLSR_SIG_WAIT) && !sig_present_in && (s_reg.tmr >= T_SWAIT) |=> s_reg.state == BLSR_FULL_RESET;
    endproperty
    a_sig_wait: assert property (p_sig_wait) else $error("no full reset after silent wait");

    property p_tone_shape;
        (tx_mode_out == BLSR_TX_TONE) && sym_tick_in && (s_reg.ph == 3'h3) |=> !tone_sym_pos_out;
    endproperty
    a_tone_shape: assert property (p_tone_shape) else $error("tone symbol group wrong");

    property p_tmr_base;
        !ms_tick
            |=> (s_reg.tmr == $past(s_reg.tmr)) || (s_reg.tmr == '0);
    endproperty
    a_tmr_base: assert property (p_tmr_base) else $error("state timer moved off the ms tick");

    property p_req_tone;
        (s_reg.state == BLSR_FULL_RESET) && s_reg.pend
            |=> tx_mode_out == BLSR_TX_TONE;
    endproperty
    a_req_tone: assert property (p_req_tone) else $error("pending request not answered with tone");

    property p_quiet;
        (s_reg.state == BLSR_FULL_RESET) && !s_reg.pend && !(s_reg.pwr && s_reg.auto_en)
            && !network_side_wake_tone_in |=> tx_mode_out == BLSR_TX_SILENT;
    endproperty
    a_quiet: assert property (p_quiet) else $error("transmission started without cause");

    property p_powerup;
        (s_reg.state == BLSR_FULL_RESET) && s_reg.pwr && s_reg.auto_en
            |=> (s_reg.state == BLSR_WAKE_TONE) && !s_reg.pwr;
    endproperty
    a_powerup: assert property (p_powerup) else $error("no start-up attempt after power-up");

    property p_sync_cease;
        (s_reg.state == BLSR_OPER) && sig_present_in && (s_reg.ltmr >= T_LOSS)
            |=> s_reg.state == BLSR_CEASE;
    endproperty
    a_sync_cease: assert property (p_sync_cease) else $error("sync loss did not stop transmission");

    property p_rx_detect;
        (s_reg.state == BLSR_CEASE) && !sig_present_in
            |=> s_reg.state == BLSR_RX_RESET;
    endproperty
    a_rx_detect: assert property (p_rx_detect) else $error("receive-reset late after signal gone");

    property p_mf_only;
        !((s_reg.state == BLSR_PAT_TWO) && multiframe_lock_in) && (s_reg.state != BLSR_OPER)
            |=> s_reg.state != BLSR_OPER;
    endproperty
    a_mf_only: assert property (p_mf_only) else $error("operation without multiframe lock");

    property p_inv_word;
        tx_mode_out != BLSR_TX_OPER
            |-> !inverted_sync_word_en_out;
    endproperty
    a_inv_word: assert property (p_inv_word) else $error("inverted word outside operation");

    property p_one_pat;
        tx_mode_out == BLSR_TX_PAT_TWO
            |-> bearer_force_one_out && !bearer_force_zero_out;
    endproperty
    a_one_pat: assert property (p_one_pat) else $error("bearer bits not one in pattern two");

    property p_one_oper;
        (tx_mode_out == BLSR_TX_OPER) && !s_reg.loop_en && !near_activation_progress_bit_in
            |-> bearer_force_one_out;
    endproperty
    a_one_oper: assert property (p_one_oper) else $error("bearer bits released before transparency");

    property p_oper_hold;
        (s_reg.state == BLSR_OPER) && sig_present_in && frame_lock_in && (s_reg.ltmr < T_LOSS)
            |=> (tx_mode_out == BLSR_TX_OPER) && (s_reg.ltmr == '0);
    endproperty
    a_oper_hold: assert property (p_oper_hold) else $error("operational pattern dropped");

    property p_tone_wrap;
        (tx_mode_out == BLSR_TX_TONE) && sym_tick_in && (s_reg.ph == 3'h7)
            |=> tone_sym_pos_out;
    endproperty
    a_tone_wrap: assert property (p_tone_wrap) else $error("tone group did not restart high");

    property p_swait_sig;
        (s_reg.state == BLSR_SIG_WAIT) && sig_present_in
            |=> s_reg.state == BLSR_ACQUIRE;
    endproperty
    a_swait_sig: assert property (p_swait_sig) else $error("arriving signal not acquired");

    property p_swait_hold;
        (s_reg.state == BLSR_SIG_WAIT) && !sig_present_in && (s_reg.tmr < T_SWAIT)
            |=> s_reg.state == BLSR_SIG_WAIT;
    endproperty
    a_swait_hold: assert property (p_swait_hold) else $error("signal wait ended early");

    property p_startup_hold;
        in_startup && (s_reg.stmr < T_START)
            |=> s_reg.state != BLSR_CEASE;
    endproperty
    a_startup_hold: assert property (p_startup_hold) else $error("start-up abandoned before timeout");
endmodule : blsr_startup_ctrl
`default_nettype wire

// *** inc/blsr_pkg.sv ***
// Notes on behaviour
// - an unfinished start-up after 15 s leads towards the reset states.
// - received signal absent over 480 ms is a reset condition.
// - synchronization lost over 480 ms is a reset condition.
// - after ceasing transmission, stay in receive-reset at least 40 ms unless answering a tone.
// - after the dwell go to full reset; a received tone may be answered at once.
// - no reset state is entered before the 480 ms loss timer expires.
// - start-up timeout or sync loss: go silent, then receive-reset once signal disappears.
// - reach receive-reset within 40 ms after the far end stops transmitting.
// - sustained loss of signal goes straight to receive-reset.
// - loss handling is armed only after multiframe synchronization.
// - full reset if no signal within 480 ms after our tone stops.
// - activation request while idle sends the customer-side wake tone.
// - cold-start-only unit attempts start-up at power-up; may fall back to full reset.
// - in reset transmit only after power cycle or new request, else wait for network tone.
// - start our wake tone within 4 ms of the network tone beginning.
// - wake tone is four +3 then four -3 symbols, no frame word.
// - patterns without multiframe send the normal sync word, never the inverted one.
// - final pattern holds bearer bits at one until both activation bits show transparency; code releases them at once while loop_en is set.
// - the operational pattern continues until turn-off.
// - wake tones are 10 kHz from the repeating unscrambled symbol groups.
package blsr_pkg;
    localparam logic [7:0] BLSR_CTRL_OFS = 8'h00;
    localparam logic [7:0] BLSR_STATUS_OFS = 8'h04;
    localparam int BLSR_CTRL_REQ_BIT = 0;
    localparam int BLSR_CTRL_AUTO_BIT = 1;
    localparam int BLSR_CTRL_LOOP_BIT = 2;
    localparam logic BLSR_AUTO_RST = 1'b1;
    localparam logic BLSR_LOOP_RST = 1'b0;
    localparam int BLSR_SYM_RATE_HZ = 80000;
    localparam int BLSR_SYMS_PER_MS = BLSR_SYM_RATE_HZ / 1000;
    localparam int BLSR_STARTUP_MS = 15000;
    localparam int BLSR_LOSS_MS = 480;
    localparam int BLSR_SIG_WAIT_MS = 480;
    localparam int BLSR_DWELL_MS = 40;
    localparam int BLSR_TONE_MS = 6;
    localparam int BLSR_TMR_W = 14;

    typedef enum logic [2:0] {
        BLSR_FULL_RESET = 3'h0,
        BLSR_WAKE_TONE = 3'h1,
        BLSR_SIG_WAIT = 3'h3,
        BLSR_ACQUIRE = 3'h2,
        BLSR_PAT_TWO = 3'h6,
        BLSR_OPER = 3'h7,
        BLSR_CEASE = 3'h5,
        BLSR_RX_RESET = 3'h4
    } blsr_state_t;

    typedef enum logic [1:0] {
        BLSR_TX_SILENT = 2'h0,
        BLSR_TX_TONE = 2'h1,
        BLSR_TX_PAT_TWO = 2'h2,
        BLSR_TX_OPER = 2'h3
    } blsr_tx_t;
endpackage : blsr_pkg

// *** dv/blsr_lt_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module blsr_lt_model import blsr_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // customer-side transmitter
    input wire logic [1:0] tx_mode_in,
    // scenario control
    input wire logic net_req_in,
    input wire logic answer_in,
    input wire logic kill_sig_in,
    input wire logic kill_frame_in,
    // line status towards the block
    output logic sig_present_out,
    output logic wake_tone_out,
    output logic frame_lock_out,
    output logic multiframe_lock_out
);
    logic heard_reg;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            heard_reg <= 1'b0;
            sig_present_out <= 1'b0;
            wake_tone_out <= 1'b0;
            frame_lock_out <= 1'b0;
            multiframe_lock_out <= 1'b0;
        end else begin
            // the customer tone is accepted whenever it comes while kill_sig_in is low
            if (kill_sig_in) begin
                heard_reg <= 1'b0;
            end else if (tx_mode_in == BLSR_TX_TONE) begin
                heard_reg <= 1'b1;
            end
            // network tone may overlap ours for a cycle before it stops
            wake_tone_out <= net_req_in && !heard_reg && tx_mode_in != BLSR_TX_TONE;
            // silent while our tone lasts, line brought up only after it stops
            sig_present_out <= heard_reg && answer_in && !kill_sig_in && tx_mode_in != BLSR_TX_TONE;
            frame_lock_out <= sig_present_out && !kill_frame_in;
            multiframe_lock_out <= frame_lock_out && tx_mode_in[1];
        end
    end
endmodule : blsr_lt_model
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top import blsr_pkg::*; ;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ack, sig, ntone, flk, mflk, inv, f1, f0, pos;
    logic [1:0] tx_mode;
    logic [1:0] cnt = 2'h0;
    logic tick = 1'b0, act_req = 1'b0, near_act = 1'b0, far_act = 1'b0;
    logic net_req = 1'b0, answer = 1'b1, kill_sig = 1'b0, kill_frame = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;

    always #5 clk_in = ~clk_in;
    // four clocks a symbol, so one ms is 16 clocks
    always @(posedge clk_in) begin
        cnt <= cnt + 2'h1;
        tick <= (cnt == 2'h3);
    end

    blsr_startup_ctrl #(.STARTUP_MS(50), .LOSS_MS(10), .SIG_WAIT_MS(10), .DWELL_MS(5), .TONE_MS(4),
        .SYMS_PER_MS(4)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .sym_tick_in(tick), .sig_present_in(sig), .network_side_wake_tone_in(ntone),
        .frame_lock_in(flk), .multiframe_lock_in(mflk), .cust_act_req_in(act_req),
        .near_activation_progress_bit_in(near_act), .far_activation_progress_bit_in(far_act),
        .tx_mode_out(tx_mode), .tone_sym_pos_out(pos), .inverted_sync_word_en_out(inv),
        .bearer_force_one_out(f1), .bearer_force_zero_out(f0));

    blsr_lt_model i_lt (.clk_in(clk_in), .rstn_in(rstn_in), .tx_mode_in(tx_mode), .net_req_in(net_req),
        .answer_in(answer), .kill_sig_in(kill_sig), .kill_frame_in(kill_frame), .sig_present_out(sig),
        .wake_tone_out(ntone), .frame_lock_out(flk), .multiframe_lock_out(mflk));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cy(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cy

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        chk("ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask : bus

    task automatic st(input logic [2:0] code);
        bus(1'b0, BLSR_STATUS_OFS, 32'h0);
        chk("state", {29'h0, code}, rd & 32'h7);
    endtask : st

    task automatic wait_tx(input logic [1:0] m, input int lim);
        int n;
        n = 0;
        while (tx_mode !== m && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        chk("tx_mode", {30'h0, m}, {30'h0, tx_mode});
    endtask : wait_tx

    task automatic t_power();
        int n;
        n = 0;
        wait_tx(BLSR_TX_TONE, 4);
        while (pos !== 1'b0 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        n = 0;
        while (pos === 1'b0 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        chk("tone_low_run", 32'h10, 32'(n));
        bus(1'b0, BLSR_CTRL_OFS, 32'h0);
        chk("ctrl", 32'h2, rd & 32'h7);
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test power_up done");
    endtask : t_power

    task automatic t_up();
        wait_tx(BLSR_TX_PAT_TWO, 400);
        chk("inv_pat_two", 32'h0, {31'h0, inv});
        chk("one_pat_two", 32'h1, {31'h0, f1});
        wait_tx(BLSR_TX_OPER, 20);
        chk("inv_oper", 32'h1, {31'h0, inv});
        chk("one_oper", 32'h1, {31'h0, f1});
        bus(1'b1, BLSR_CTRL_OFS, 32'h6);
        chk("one_loop", 32'h0, {31'h0, f1});
        bus(1'b1, BLSR_CTRL_OFS, 32'h2);
        chk("one_no_loop", 32'h1, {31'h0, f1});
        near_act <= 1'b1;
        far_act <= 1'b1;
        cy(3);
        chk("one_transparent", 32'h0, {31'h0, f1});
        chk("zero_force", 32'h0, {31'h0, f0});
        cy(100);
        wait_tx(BLSR_TX_OPER, 1);
        $display("test start_up done");
    endtask : t_up

    task automatic t_los();
        kill_sig <= 1'b1;
        cy(130);
        wait_tx(BLSR_TX_OPER, 1);
        wait_tx(BLSR_TX_SILENT, 40);
        st(3'h4);
        cy(40);
        st(3'h4);
        cy(50);
        st(3'h0);
        bus(1'b1, BLSR_CTRL_OFS, 32'h7, 4'h0);
        bus(1'b0, BLSR_CTRL_OFS, 32'h0);
        chk("ctrl_no_sel", 32'h2, rd & 32'h7);
        cy(200);
        wait_tx(BLSR_TX_SILENT, 1);
        $display("test signal_loss done");
    endtask : t_los

    task automatic t_net();
        answer <= 1'b0;
        kill_sig <= 1'b0;
        net_req <= 1'b1;
        wait_tx(BLSR_TX_TONE, 64);
        net_req <= 1'b0;
        wait_tx(BLSR_TX_SILENT, 100);
        cy(120);
        st(3'h3);
        cy(60);
        st(3'h0);
        $display("test network_tone done");
    endtask : t_net

    task automatic t_req();
        kill_sig <= 1'b1;
        cy(1);
        kill_sig <= 1'b0;
        answer <= 1'b1;
        act_req <= 1'b1;
        cy(1);
        act_req <= 1'b0;
        wait_tx(BLSR_TX_TONE, 4);
        wait_tx(BLSR_TX_OPER, 400);
        $display("test request done");
    endtask : t_req

    task automatic t_sync();
        kill_frame <= 1'b1;
        cy(130);
        wait_tx(BLSR_TX_OPER, 1);
        wait_tx(BLSR_TX_SILENT, 40);
        st(3'h5);
        cy(40);
        st(3'h5);
        kill_sig <= 1'b1;
        cy(4);
        st(3'h4);
        bus(1'b1, BLSR_CTRL_OFS, 32'h3);
        st(3'h4);
        chk("pend", 32'h1, (rd >> 6) & 32'h1);
        wait_tx(BLSR_TX_TONE, 100);
        kill_sig <= 1'b0;
        cy(700);
        st(3'h2);
        cy(120);
        st(3'h5);
        $display("test sync_loss done");
    endtask : t_sync

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        cy(20000);
        n_fail++;
        $display("mismatch watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        cy(10);
        rstn_in <= 1'b1;
        cy(1);
        t_power();
        t_up();
        t_los();
        t_net();
        t_req();
        t_sync();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
